// File: verilog/reconfig_port_host.sv
/*
 * Master end: runs the unlock sequence, then turns user requests
 * into single port accesses and returns read data.
 * Assumes ref_clk_i is the port clock and user inputs share it.
 */
`timescale 1ns/1ps
module reconfig_port_host (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    reconfig_if.host bus,
    input wire logic user_mode_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [reconfig_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [reconfig_pkg::DATA_W-1:0] req_wdata_i,
    input wire logic relink_done_i,
    output logic ready_o,
    output logic busy_o,
    output logic rsp_valid_o,
    output logic [reconfig_pkg::DATA_W-1:0] rsp_data_o,
    output logic relink_needed_o
);
    typedef enum logic [2:0] {
        ST_WAIT_USER,
        ST_LOAD,
        ST_HOLD_SEL,
        ST_IDLE,
        ST_WRITE,
        ST_READ,
        ST_READ_WAIT
    } host_state_t;

    host_state_t state_q, state_d;
    logic [reconfig_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic shift_load_q, shift_load_d;
    logic sel_q, sel_d;
    logic read_q, read_d;
    logic write_q, write_d;
    logic [reconfig_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [reconfig_pkg::DATA_W-1:0] wdata_q, wdata_d;
    logic ready_q, ready_d;
    logic busy_q, busy_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [reconfig_pkg::DATA_W-1:0] rsp_data_q, rsp_data_d;
    logic relink_q, relink_d;
    logic set_relink;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_load_d = shift_load_q;
        sel_d = sel_q;
        read_d = 1'b0;
        write_d = 1'b0;
        addr_d = addr_q;
        wdata_d = wdata_q;
        ready_d = ready_q;
        busy_d = busy_q;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        set_relink = 1'b0;

        case (state_q)
            ST_WAIT_USER: begin
                if (user_mode_i) begin
                    // Single pulse of shift/load acts as the toggle
                    shift_load_d = 1'b1;
                    sel_d = 1'b1;
                    cnt_d = reconfig_pkg::CNT_LOAD;
                    busy_d = 1'b1;
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (cnt_q == reconfig_pkg::CNT_ZERO) begin
                    shift_load_d = 1'b0;
                    cnt_d = reconfig_pkg::CNT_SEL;
                    state_d = ST_HOLD_SEL;
                end else begin
                    cnt_d = cnt_q - reconfig_pkg::CNT_ONE;
                end
            end
            ST_HOLD_SEL: begin
                if (cnt_q == reconfig_pkg::CNT_ZERO) begin
                    sel_d = 1'b0;
                    busy_d = 1'b0;
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - reconfig_pkg::CNT_ONE;
                end
            end
            ST_IDLE: begin
                // Requests wait until unlock is done and nothing is open
                if (req_i && ready_q) begin
                    ready_d = 1'b0;
                    busy_d = 1'b1;
                    sel_d = 1'b1;
                    addr_d = req_addr_i;
                    if (req_write_i) begin
                        write_d = 1'b1;
                        wdata_d = req_wdata_i;
                        state_d = ST_WRITE;
                    end else begin
                        read_d = 1'b1;
                        state_d = ST_READ;
                    end
                end
            end
            ST_WRITE: begin
                // Any write may alter a read-only value
                set_relink = 1'b1;
                sel_d = 1'b0;
                busy_d = 1'b0;
                ready_d = 1'b1;
                state_d = ST_IDLE;
            end
            ST_READ: begin
                cnt_d = reconfig_pkg::CNT_RD;
                state_d = ST_READ_WAIT;
            end
            ST_READ_WAIT: begin
                // Data only stands after the third edge; take it one later
                if (cnt_q == reconfig_pkg::CNT_ZERO) begin
                    rsp_data_d = bus.readdata;
                    rsp_valid_d = 1'b1;
                    sel_d = 1'b0;
                    busy_d = 1'b0;
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - reconfig_pkg::CNT_ONE;
                end
            end
            default: begin
                state_d = ST_WAIT_USER;
                shift_load_d = 1'b0;
                sel_d = 1'b0;
                ready_d = 1'b0;
                busy_d = 1'b0;
            end
        endcase

        // Set wins over a clear in the same cycle
        relink_d = set_relink | (relink_q & ~relink_done_i);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_WAIT_USER;
            cnt_q <= reconfig_pkg::CNT_ZERO;
            shift_load_q <= 1'b0;
            sel_q <= 1'b0;
            read_q <= 1'b0;
            write_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= reconfig_pkg::REG_DEFAULT;
            ready_q <= 1'b0;
            busy_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= reconfig_pkg::REG_DEFAULT;
            relink_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_load_q <= shift_load_d;
            sel_q <= sel_d;
            read_q <= read_d;
            write_q <= write_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            ready_q <= ready_d;
            busy_q <= busy_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            relink_q <= relink_d;
        end
    end

    // Port clock here is 40 MHz; a real part wants 100 to 125 MHz
    assign bus.address = addr_q;
    assign bus.read = read_q;
    assign bus.write = write_q;
    assign bus.writedata = wdata_q;
    assign bus.byte_en = reconfig_pkg::BE_ALL;
    assign bus.shift_load = shift_load_q;
    assign bus.interface_sel = sel_q;
    assign ready_o = ready_q;
    assign busy_o = busy_q;
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o = rsp_data_q;
    assign relink_needed_o = relink_q;
endmodule

// File: verilog/reconfig_pkg.sv
/*
 * Shared constants for the reconfiguration port: widths, depth,
 * read latency and the unlock sequence timing.
 * Assumes one 40 MHz clock for both ends of the port.
 */
package reconfig_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int BE_W = 2;
    localparam int DEPTH = 1024;
    localparam logic [DATA_W-1:0] REG_DEFAULT = 16'h0000;
    localparam logic [BE_W-1:0] BE_ALL = 2'h3;

    // Read data appears on the third cycle after the read strobe
    localparam int RD_LATENCY = 3;

    // Reconfiguration clock range the far end must supply
    localparam int RECONFIG_CLK_MIN_MHZ = 100;
    localparam int RECONFIG_CLK_MAX_MHZ = 125;

    localparam int CLK_PERIOD_NS = 25;
    localparam int SHIFT_LOAD_MIN_NS = 324;
    localparam int SHIFT_LOAD_CYCLES =
        (SHIFT_LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEL_DROP_CYCLES = 4;

    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_LOAD = 5'(SHIFT_LOAD_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_SEL = 5'(SEL_DROP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_RD = 5'(RD_LATENCY - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
endpackage

// File: verilog/reconfig_if.sv
/*
 * Interface joining the reconfiguration master and the port.
 * Assumes both ends run on the same clock; no clocking block.
 */
`timescale 1ns/1ps
interface reconfig_if;
    logic [reconfig_pkg::ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [reconfig_pkg::DATA_W-1:0] writedata;
    logic [reconfig_pkg::DATA_W-1:0] readdata;
    logic [reconfig_pkg::BE_W-1:0] byte_en;
    logic shift_load;
    logic interface_sel;

    modport dev (
        input address,
        input read,
        input write,
        input writedata,
        output readdata,
        input byte_en,
        input shift_load,
        input interface_sel
    );

    modport host (
        output address,
        output read,
        output write,
        output writedata,
        input readdata,
        output byte_en,
        output shift_load,
        output interface_sel
    );
endinterface

// File: verilog/reconfig_port_dev.sv
/*
 * Device end: the reconfigurable register store behind the port.
 * Assumes the master keeps the unlock sequence and waits out reads.
 */
`timescale 1ns/1ps
module reconfig_port_dev (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    reconfig_if.dev bus,
    input wire logic [reconfig_pkg::ADDR_W-1:0] cfg_addr_i,
    output logic [reconfig_pkg::DATA_W-1:0] cfg_data_o,
    output logic unlocked_o
);
    logic [reconfig_pkg::DATA_W-1:0] regs_q [reconfig_pkg::DEPTH];
    logic shift_prev_q, shift_prev_d;
    logic unlocked_q, unlocked_d;
    logic access_ok;
    logic wr_en;
    logic [1:0] rd_pipe_q, rd_pipe_d;
    logic [reconfig_pkg::ADDR_W-1:0] rd_addr_q, rd_addr_d;
    logic [reconfig_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic [reconfig_pkg::DATA_W-1:0] cfg_q, cfg_d;

    // Byte enables are not looked at; whole words only
    always_comb begin
        shift_prev_d = bus.shift_load;
        // Unlock on the falling edge of the shift/load strobe
        unlocked_d = unlocked_q | (shift_prev_q & ~bus.shift_load);
        access_ok = unlocked_q & bus.interface_sel;
        wr_en = bus.write & access_ok;
        rd_pipe_d = {rd_pipe_q[0], bus.read & access_ok};
        rd_addr_d = bus.read ? bus.address : rd_addr_q;
        rdata_d = rd_pipe_q[1] ? regs_q[rd_addr_q] : rdata_q;
        cfg_d = regs_q[cfg_addr_i];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_prev_q <= 1'b0;
            unlocked_q <= 1'b0;
            rd_pipe_q <= 2'h0;
            rd_addr_q <= '0;
            rdata_q <= reconfig_pkg::REG_DEFAULT;
            cfg_q <= reconfig_pkg::REG_DEFAULT;
        end else begin
            shift_prev_q <= shift_prev_d;
            unlocked_q <= unlocked_d;
            rd_pipe_q <= rd_pipe_d;
            rd_addr_q <= rd_addr_d;
            rdata_q <= rdata_d;
            cfg_q <= cfg_d;
        end
    end

    // Full reset of the store is costly in area but keeps defaults exact
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < reconfig_pkg::DEPTH; i++) begin
                regs_q[i] <= reconfig_pkg::REG_DEFAULT;
            end
        end else if (wr_en) begin
            regs_q[bus.address] <= bus.writedata;
        end
    end

    assign bus.readdata = rdata_q;
    assign cfg_data_o = cfg_q;
    assign unlocked_o = unlocked_q;
endmodule

// File: dv/reconfig_sva.sv
/*
 * Checker on the port signals between host and device ends.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module reconfig_sva (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [reconfig_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [reconfig_pkg::DATA_W-1:0] writedata,
    input wire logic [reconfig_pkg::DATA_W-1:0] readdata,
    input wire logic [reconfig_pkg::BE_W-1:0] byte_en,
    input wire logic shift_load,
    input wire logic interface_sel
);
    logic sl_q, seen_q, seen_d;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Unlock counts from the first release of shift/load
    always_comb seen_d = seen_q | (sl_q & !shift_load);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {sl_q, seen_q} <= 2'h0;
        end else begin
            {sl_q, seen_q} <= {shift_load, seen_d};
        end
    end

    sequence load_hold;
        shift_load [*8] ##1 shift_load [*5];
    endsequence
    sequence sel_tail;
        interface_sel [*4] ##1 !interface_sel;
    endsequence

    a_load_hold_min: assert property ($rose(shift_load) |-> load_hold)
        else $error("shift/load pulse too short");
    a_sel_drop_four: assert property ($fell(shift_load) |-> sel_tail)
        else $error("select not dropped four cycles after release");
    a_unlock_once: assert property ($rose(shift_load) |-> !seen_q)
        else $error("shift/load toggled twice");
    a_access_unlocked: assert property ((read || write) |-> seen_q)
        else $error("access before unlock");
    a_sel_on_access: assert property ((read || write) |-> interface_sel)
        else $error("access without select");
    a_read_no_overlap: assert property (read |=> !read [*3])
        else $error("read issued while one outstanding");
    a_rdata_latency: assert property (!$stable(readdata) |-> $past(read, 3))
        else $error("read data changed off its latency");
    a_write_single: assert property (write |=> !write && !read)
        else $error("write strobe held");
    a_byte_en_full: assert property (byte_en == reconfig_pkg::BE_ALL)
        else $error("partial byte enables");
    a_reset_default: assert property (disable iff (1'b0)
        $rose(rst_n_i) |-> readdata == reconfig_pkg::REG_DEFAULT)
        else $error("read data not default after reset");
endmodule

// File: dv/test_hard_ip_reconfig_port.sv
/*
 * Bench joining host and device ends, user side driven here.
 * Assumes a 40 MHz clock and the host's hand-over timing.
 */
`timescale 1ns/1ps
module test_hard_ip_reconfig_port;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic user_mode_i = 1'b0;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [9:0] req_addr_i = 10'h000;
    logic [15:0] req_wdata_i = 16'h0000;
    logic relink_done_i = 1'b0;
    logic [9:0] cfg_addr_i = 10'h000;
    logic ready_o, busy_o, rsp_valid_o, relink_needed_o, unlocked_o;
    logic [15:0] rsp_data_o, cfg_data_o;
    logic [15:0] mdl [1024];
    logic [15:0] expq [$];
    logic [9:0] adr [8];
    logic [31:0] seed = 32'hF422ECDD;
    int n_fail = 0;
    int checks = 0;

    reconfig_if bus ();
    reconfig_port_host u_reconfig_port_host (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .bus(bus), .user_mode_i(user_mode_i),
        .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .relink_done_i(relink_done_i),
        .ready_o(ready_o), .busy_o(busy_o), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .relink_needed_o(relink_needed_o));
    reconfig_port_dev u_reconfig_port_dev (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .bus(bus), .cfg_addr_i(cfg_addr_i),
        .cfg_data_o(cfg_data_o), .unlocked_o(unlocked_o));
    reconfig_sva u_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .address(bus.address), .read(bus.read), .write(bus.write),
        .writedata(bus.writedata), .readdata(bus.readdata),
        .byte_en(bus.byte_en), .shift_load(bus.shift_load),
        .interface_sel(bus.interface_sel));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Bounded so a stuck host shows as a mismatch, not a hang
    task automatic wait_ready();
        int n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ready_o !== 1'b1 && n < 100);
        if (n >= 100) chk(16'h0000, 16'h0001);
    endtask

    task automatic access(input logic w, input logic [9:0] a,
                          input logic [15:0] d);
        wait_ready();
        req_i <= 1'b1;
        req_write_i <= w;
        req_addr_i <= a;
        req_wdata_i <= d;
        if (w) mdl[a] = d;
        else expq.push_back(mdl[a]);
        @(posedge ref_clk_i);
        req_i <= 1'b0;
    endtask

    task automatic cfg_chk(input logic [9:0] a);
        cfg_addr_i <= a;
        repeat (2) @(posedge ref_clk_i);
        chk(cfg_data_o, mdl[a]);
    endtask

    task automatic reset_dut();
        rst_n_i <= 1'b0;
        user_mode_i <= 1'b0;
        foreach (mdl[i]) mdl[i] = reconfig_pkg::REG_DEFAULT;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
    endtask

    task automatic unlock();
        user_mode_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(16'(busy_o), 16'h0001);
        wait_ready();
        chk(16'(busy_o), 16'h0000);
        chk(16'(unlocked_o), 16'h0001);
    endtask

    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_fail++;
        stop_test();
    end

    always @(posedge ref_clk_i) begin
        if (rsp_valid_o === 1'b1) begin
            if (expq.size() == 0) chk(rsp_data_o, 16'hXXXX);
            else chk(rsp_data_o, expq.pop_front());
        end
    end

    initial begin
        reset_dut();
        chk(16'(ready_o), 16'h0000);
        cfg_chk(10'h3FF);
        unlock();
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            adr[i] = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : seed[9:0];
            access(1'b1, adr[i], seed[31:16]);
        end
        wait_ready();
        @(posedge ref_clk_i);
        chk(16'(relink_needed_o), 16'h0001);
        relink_done_i <= 1'b1;
        @(posedge ref_clk_i);
        relink_done_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk(16'(relink_needed_o), 16'h0000);
        foreach (adr[i]) access(1'b0, adr[i], seed[15:0]);
        foreach (adr[i]) cfg_chk(adr[i]);
        reset_dut();
        unlock();
        foreach (adr[i]) access(1'b0, adr[i], 16'h0000);
        wait_ready();
        repeat (2) @(posedge ref_clk_i);
        chk(16'(expq.size()), 16'h0000);
        stop_test();
    end
endmodule
